//--- pkg/pim_defines.svh
// register offsets, field positions, reset values and timing figures of the mask and limit slice
`ifndef PIM_DEFINES_SVH
`define PIM_DEFINES_SVH

`define PIM_OFS_MASK2        8'h0c
`define PIM_OFS_MASK3        8'h0d
`define PIM_OFS_ILIM         8'h0f

`define PIM_BIT_BUCK_A       2
`define PIM_BIT_BUCK_B       1
`define PIM_BIT_BUCK_C       0

`define PIM_BIT_BATT_OK      7
`define PIM_BIT_REG_DONE     6
`define PIM_BIT_BOOST_FAULT  5
`define PIM_BIT_RSVD3        4
`define PIM_BIT_CRC_ERR      3
`define PIM_BIT_SER_TMO      2
`define PIM_BIT_HAPTIC       1
`define PIM_BIT_CONVERTER    0

`define PIM_FLOOR_MSB        7
`define PIM_FLOOR_LSB        5
`define PIM_BLANK_MSB        4
`define PIM_BLANK_LSB        3
`define PIM_LIMIT_MSB        2
`define PIM_LIMIT_LSB        0

`define PIM_RST_MASK2        3'h0
`define PIM_RST_MASK3        8'h00
`define PIM_RST_ILIM         8'h00
`define PIM_MASK3_USED       8'hef

`define PIM_CLK_PERIOD_PS    5000
`define PIM_BLANK1_US_X10    5
`define PIM_BLANK2_US_X10    10
`define PIM_BLANK3_US_X10    100
`define PIM_CYC_PER_100US    (100000000 / `PIM_CLK_PERIOD_PS)
`define PIM_BLANK1_CYC       (`PIM_BLANK1_US_X10 * `PIM_CYC_PER_100US)
`define PIM_BLANK2_CYC       (`PIM_BLANK2_US_X10 * `PIM_CYC_PER_100US)
`define PIM_BLANK3_CYC       (`PIM_BLANK3_US_X10 * `PIM_CYC_PER_100US)

`define PIM_DEV_ADDR         7'h3c

`endif

//--- pkg/pim_pkg.sv
// types shared by the serial port and the register slice
package pim_pkg;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pim_bus_type;

    typedef struct packed {
        logic [2:0] buck_thermal;
        logic [7:0] group3;
    } pim_flags_type;

    typedef enum logic [3:0] {
        PIM_ST_IDLE    = 4'h0,
        PIM_ST_DEV     = 4'h1,
        PIM_ST_DEV_ACK = 4'h3,
        PIM_ST_PTR     = 4'h2,
        PIM_ST_PTR_ACK = 4'h6,
        PIM_ST_WR      = 4'h7,
        PIM_ST_WR_ACK  = 4'h5,
        PIM_ST_RD      = 4'h4,
        PIM_ST_RD_ACK  = 4'hc
    } pim_state_type;

endpackage : pim_pkg

//--- src/pim_serial_port.sv
// two-wire serial slave that turns bus frames into register writes and reads
`timescale 1ns/1ps
`default_nettype none
`include "pim_defines.svh"

module pim_serial_port #(
    parameter logic [6:0] DEV_ADDR = `PIM_DEV_ADDR
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe,
    output pim_pkg::pim_bus_type      bus,
    output logic [7:0]                rd_addr,
    input  wire logic [7:0]           rd_data
);

    logic [1:0]             scl_sync_reg;
    logic [1:0]             sda_sync_reg;
    logic                   scl_d_reg;
    logic                   sda_d_reg;
    logic                   rise;
    logic                   fall;
    logic                   start_c;
    logic                   stop_c;
    pim_pkg::pim_state_type st_reg;
    logic [7:0]             sh_reg;
    logic [3:0]             cnt_reg;
    logic [7:0]             ptr_reg;
    logic                   rw_reg;
    logic                   ack_reg;
    logic                   low_reg;

    // two-stage resync of the bus pins
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            scl_d_reg    <= scl_sync_reg[1];
            sda_d_reg    <= sda_sync_reg[1];
        end
    end

    assign rise    = scl_sync_reg[1] & ~scl_d_reg;
    assign fall    = ~scl_sync_reg[1] & scl_d_reg;
    assign start_c = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];
    assign stop_c  = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];
    assign rd_addr = ptr_reg;
    assign sda_o   = 1'b0;
    assign sda_oe  = low_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg  <= pim_pkg::PIM_ST_IDLE;
            sh_reg  <= 8'h00;
            cnt_reg <= 4'h0;
            ptr_reg <= 8'h00;
            rw_reg  <= 1'b0;
            ack_reg <= 1'b0;
            low_reg <= 1'b0;
            bus     <= '0;
        end
        else
        begin
            bus.wr <= 1'b0;
            if (start_c)
            begin
                st_reg  <= pim_pkg::PIM_ST_DEV;
                cnt_reg <= 4'h0;
                low_reg <= 1'b0;
            end
            else if (stop_c)
            begin
                st_reg  <= pim_pkg::PIM_ST_IDLE;
                low_reg <= 1'b0;
            end
            else if (rise)
            begin
                if (st_reg == pim_pkg::PIM_ST_RD_ACK)
                    ack_reg <= ~sda_sync_reg[1];
                else if (st_reg != pim_pkg::PIM_ST_RD && st_reg != pim_pkg::PIM_ST_IDLE)
                begin
                    sh_reg  <= {sh_reg[6:0], sda_sync_reg[1]};
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end
            else if (fall)
            begin
                case (st_reg)
                    pim_pkg::PIM_ST_DEV:
                        if (cnt_reg == 4'h8)
                        begin
                            if (sh_reg[7:1] == DEV_ADDR)
                            begin
                                st_reg  <= pim_pkg::PIM_ST_DEV_ACK;
                                rw_reg  <= sh_reg[0];
                                low_reg <= 1'b1;
                            end
                            else
                                st_reg <= pim_pkg::PIM_ST_IDLE;
                        end
                    pim_pkg::PIM_ST_DEV_ACK:
                        if (rw_reg)
                        begin
                            st_reg  <= pim_pkg::PIM_ST_RD;
                            low_reg <= ~rd_data[7];
                            sh_reg  <= {rd_data[6:0], 1'b1};
                            cnt_reg <= 4'h1;
                            ptr_reg <= ptr_reg + 8'h01;
                        end
                        else
                        begin
                            st_reg  <= pim_pkg::PIM_ST_PTR;
                            low_reg <= 1'b0;
                            cnt_reg <= 4'h0;
                        end
                    pim_pkg::PIM_ST_PTR:
                        if (cnt_reg == 4'h8)
                        begin
                            ptr_reg <= sh_reg;
                            low_reg <= 1'b1;
                            st_reg  <= pim_pkg::PIM_ST_PTR_ACK;
                        end
                    pim_pkg::PIM_ST_WR:
                        if (cnt_reg == 4'h8)
                        begin
                            bus.wr    <= 1'b1;
                            bus.addr  <= ptr_reg;
                            bus.wdata <= sh_reg;
                            low_reg   <= 1'b1;
                            st_reg    <= pim_pkg::PIM_ST_WR_ACK;
                        end
                    pim_pkg::PIM_ST_PTR_ACK, pim_pkg::PIM_ST_WR_ACK:
                    begin
                        if (st_reg == pim_pkg::PIM_ST_WR_ACK)
                            ptr_reg <= ptr_reg + 8'h01;
                        low_reg <= 1'b0;
                        cnt_reg <= 4'h0;
                        st_reg  <= pim_pkg::PIM_ST_WR;
                    end
                    pim_pkg::PIM_ST_RD:
                        if (cnt_reg == 4'h8)
                        begin
                            low_reg <= 1'b0;
                            st_reg  <= pim_pkg::PIM_ST_RD_ACK;
                        end
                        else
                        begin
                            low_reg <= ~sh_reg[7];
                            sh_reg  <= {sh_reg[6:0], 1'b1};
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    pim_pkg::PIM_ST_RD_ACK:
                        if (ack_reg)
                        begin
                            st_reg  <= pim_pkg::PIM_ST_RD;
                            low_reg <= ~rd_data[7];
                            sh_reg  <= {rd_data[6:0], 1'b1};
                            cnt_reg <= 4'h1;
                            ptr_reg <= ptr_reg + 8'h01;
                        end
                        else
                        begin
                            low_reg <= 1'b0;
                            st_reg  <= pim_pkg::PIM_ST_IDLE;
                        end
                    default:
                        st_reg <= pim_pkg::PIM_ST_IDLE;
                endcase
            end
        end
    end

endmodule : pim_serial_port
`default_nettype wire

//--- src/pim_regs.sv
// interrupt mask and input limiter register slice behind the two-wire port
// What this block does
// R1 - bit 2 of 0x0C masks buck A thermal
// R2 - bit 1 masks buck B thermal
// R3 - bit 0 masks buck C thermal
// R4 - 0x0D bit 1 masks haptic status
// R5 - other 0x0D bits mask group3, bit4 reserved
// R6 - bits 7:5 of 0x0F select floor voltage
// R7 - bits 4:3 select limiter blanking time
// R8 - bits 2:0 select input current limit
`timescale 1ns/1ps
`default_nettype none
`include "pim_defines.svh"

module pim_regs #(
    parameter logic [6:0]  DEV_ADDR   = `PIM_DEV_ADDR,
    parameter int unsigned BLANK1_CYC = `PIM_BLANK1_CYC,
    parameter int unsigned BLANK2_CYC = `PIM_BLANK2_CYC,
    parameter int unsigned BLANK3_CYC = `PIM_BLANK3_CYC,
    parameter int unsigned CNT_W      = 21
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe,
    input  wire pim_pkg::pim_flags_type flags,
    output logic [2:0]                 buck_thermal_irq,
    output logic [7:0]                 group3_irq,
    output logic                       irq_request,
    input  wire logic                  limit_detect_i,
    output logic                       limit_active,
    output logic [2:0]                 system_floor_voltage_sel,
    output logic [1:0]                 limiter_blanking_sel,
    output logic [2:0]                 input_limit_sel
);

    // refuse counts the blanking counter cannot hold
    if (CNT_W > 31 || (64'd1 << CNT_W) <= 64'(BLANK3_CYC) || BLANK1_CYC == 0
        || BLANK1_CYC > BLANK2_CYC || BLANK2_CYC > BLANK3_CYC)
    begin : g_bad_blank_cfg
        $error("pim_regs: blanking counts do not fit the counter");
    end

    pim_pkg::pim_bus_type bus;
    logic [7:0]           rd_addr;
    logic [7:0]           rd_data;
    logic [2:0]           mask2_reg;
    logic [7:0]           mask3_reg;
    logic [7:0]           ilim_reg;
    logic [1:0]           det_sync_reg;
    logic [CNT_W-1:0]     blank_cnt_reg;
    logic [CNT_W-1:0]     blank_target;
    logic                 limit_reg;

    pim_serial_port #(
        .DEV_ADDR (DEV_ADDR)
    ) u_port (
        .clk     (clk),
        .rst     (rst),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .sda_o   (sda_o),
        .sda_oe  (sda_oe),
        .bus     (bus),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    // buck thermal masks, one bit per source
    always_ff @(posedge clk)
    begin
        if (rst)
            mask2_reg <= `PIM_RST_MASK2;
        // R1 - buck A write
        // R2 - buck B write
        // R3 - buck C write
        else if (bus.wr && bus.addr == `PIM_OFS_MASK2)
            mask2_reg <= bus.wdata[2:0];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            mask3_reg <= `PIM_RST_MASK3;
        // R4 - haptic mask write
        // R5 - reserved bit dropped
        else if (bus.wr && bus.addr == `PIM_OFS_MASK3)
            mask3_reg <= bus.wdata & `PIM_MASK3_USED;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            ilim_reg <= `PIM_RST_ILIM;
        // R6 - limit fields write
        else if (bus.wr && bus.addr == `PIM_OFS_ILIM)
            ilim_reg <= bus.wdata;
    end

    always_comb
    begin
        case (rd_addr)
            `PIM_OFS_MASK2: rd_data = {5'h00, mask2_reg};
            `PIM_OFS_MASK3: rd_data = mask3_reg;
            `PIM_OFS_ILIM:  rd_data = ilim_reg;
            default:        rd_data = 8'h00;
        endcase
    end

    // mask gating, 1 lets the flag through
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            buck_thermal_irq <= 3'h0;
            group3_irq       <= 8'h00;
            irq_request      <= 1'b0;
        end
        else
        begin
            // R1 - buck thermal gating
            buck_thermal_irq <= flags.buck_thermal & mask2_reg;
            // R4 - group3 gating
            group3_irq       <= flags.group3 & mask3_reg;
            irq_request      <= |(flags.buck_thermal & mask2_reg)
                                | |(flags.group3 & mask3_reg);
        end
    end

    // R6 - analog selects
    // R8 - limit code out
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            system_floor_voltage_sel <= 3'h0;
            limiter_blanking_sel     <= 2'h0;
            input_limit_sel          <= 3'h0;
        end
        else
        begin
            system_floor_voltage_sel <= ilim_reg[`PIM_FLOOR_MSB:`PIM_FLOOR_LSB];
            limiter_blanking_sel     <= ilim_reg[`PIM_BLANK_MSB:`PIM_BLANK_LSB];
            input_limit_sel          <= ilim_reg[`PIM_LIMIT_MSB:`PIM_LIMIT_LSB];
        end
    end

    // R7 - blanking length
    always_comb
    begin
        case (ilim_reg[`PIM_BLANK_MSB:`PIM_BLANK_LSB])
            2'h1:    blank_target = CNT_W'(BLANK1_CYC);
            2'h2:    blank_target = CNT_W'(BLANK2_CYC);
            2'h3:    blank_target = CNT_W'(BLANK3_CYC);
            default: blank_target = '0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            det_sync_reg <= 2'h0;
        else
            det_sync_reg <= {det_sync_reg[0], limit_detect_i};
    end

    // R7 - debounce limiter detect
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            limit_reg     <= 1'b0;
            blank_cnt_reg <= '0;
        end
        else if (det_sync_reg[1] == limit_reg)
            blank_cnt_reg <= '0;
        else if (blank_cnt_reg >= blank_target)
        begin
            limit_reg     <= det_sync_reg[1];
            blank_cnt_reg <= '0;
        end
        else
            blank_cnt_reg <= blank_cnt_reg + CNT_W'(1);
    end

    assign limit_active = limit_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_BUCK_A_MASK: assert property ( // R1
        buck_thermal_irq[`PIM_BIT_BUCK_A]
            |-> $past(flags.buck_thermal[`PIM_BIT_BUCK_A] && mask2_reg[`PIM_BIT_BUCK_A]))
        else $error("buck A irq passed while masked");

    AST_BUCK_B_WRITE: assert property ( // R2
        bus.wr && bus.addr == `PIM_OFS_MASK2 ##1 flags.buck_thermal[`PIM_BIT_BUCK_B]
            |=> buck_thermal_irq[`PIM_BIT_BUCK_B] == $past(mask2_reg[`PIM_BIT_BUCK_B]))
        else $error("buck B mask not applied");

    AST_BUCK_C_MASKED: assert property ( // R3
        !mask2_reg[`PIM_BIT_BUCK_C] |=> !buck_thermal_irq[`PIM_BIT_BUCK_C])
        else $error("buck C irq passed while masked");

    AST_HAPTIC_GATE: assert property ( // R4
        flags.group3[`PIM_BIT_HAPTIC] && mask3_reg[`PIM_BIT_HAPTIC]
            |=> group3_irq[`PIM_BIT_HAPTIC] && irq_request)
        else $error("unmasked haptic irq lost");

    AST_RSVD_ZERO: assert property ( // R5
        bus.wr && bus.addr == `PIM_OFS_MASK3
            |=> !mask3_reg[`PIM_BIT_RSVD3]
                && mask3_reg[`PIM_BIT_BATT_OK] == $past(bus.wdata[`PIM_BIT_BATT_OK]))
        else $error("group3 mask write wrong");

    AST_FLOOR_SEL: assert property ( // R6
        bus.wr && bus.addr == `PIM_OFS_ILIM
            |=> ##1 system_floor_voltage_sel == $past(bus.wdata[7:5], 2))
        else $error("floor voltage select not updated");

    AST_NO_DEBOUNCE: assert property ( // R7
        ilim_reg[`PIM_BLANK_MSB:`PIM_BLANK_LSB] == 2'h0
            && det_sync_reg[1] != limit_reg |=> limit_reg == $past(det_sync_reg[1]))
        else $error("code zero must follow in one cycle");

    AST_BLANK_HOLD: assert property ( // R7
        $changed(limit_reg) |-> $past(blank_cnt_reg) >= $past(blank_target))
        else $error("limiter output changed before blanking time");

    AST_LIMIT_SEL: assert property ( // R8
        bus.wr && bus.addr == `PIM_OFS_ILIM
            |=> ##1 input_limit_sel == $past(bus.wdata[2:0], 2))
        else $error("limit code not updated");

    COV_MASK3_WRITE: cover property (bus.wr && bus.addr == `PIM_OFS_MASK3);
    COV_ILIM_WRITE: cover property (bus.wr && bus.addr == `PIM_OFS_ILIM);
    COV_IRQ: cover property (irq_request);
    COV_LIMIT_RISE: cover property ($rose(limit_reg) && limiter_blanking_sel != 2'h0);

endmodule : pim_regs
`default_nettype wire

//--- test/pim_host_model.sv
// host-side two-wire bus master that reaches the register slice
`timescale 1ns/1ps
`default_nettype none
`include "pim_defines.svh"

module pim_host_model #(
    parameter int PHASE = 11
) (
    input  wire logic clk,
    input  wire logic sda_line,
    output var logic  scl,
    output var logic  sda_low
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // also serves as repeated start after an acknowledge bit
    task automatic start_cond();
        sda_low = 1'b0;
        tick(PHASE);
        scl = 1'b1;
        tick(PHASE);
        sda_low = 1'b1;
        tick(PHASE);
        scl = 1'b0;
        tick(PHASE);
    endtask : start_cond

    task automatic stop_cond();
        sda_low = 1'b1;
        tick(PHASE);
        scl = 1'b1;
        tick(PHASE);
        sda_low = 1'b0;
        tick(PHASE);
    endtask : stop_cond

    // data moves only while scl is low, sampled at end of high phase
    task automatic bit_xfer(input logic b, output logic s);
        sda_low = ~b;
        tick(PHASE);
        scl = 1'b1;
        tick(PHASE);
        s = sda_line;
        scl = 1'b0;
        tick(PHASE);
    endtask : bit_xfer

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_xfer(b[i], s);
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask : send_byte

    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(1'b1, s);
            b[i] = s;
        end
        bit_xfer(last, s);
    endtask : recv_byte

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] addr,
                             input logic [7:0] data, output logic ok);
        logic a0, a1, a2;
        start_cond();
        send_byte({dev, 1'b0}, a0);
        send_byte(addr, a1);
        send_byte(data, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                            output logic ok);
        logic a0, a1, a2;
        start_cond();
        send_byte({`PIM_DEV_ADDR, 1'b0}, a0);
        send_byte(addr, a1);
        start_cond();
        send_byte({`PIM_DEV_ADDR, 1'b1}, a2);
        recv_byte(1'b1, data);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask : read_reg
endmodule : pim_host_model
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the mask and input limiter register slice
`timescale 1ns/1ps
`default_nettype none
`include "pim_defines.svh"

module testbench;
    localparam int blank_cyc [4] = '{0, 4, 8, 16};

    logic                   clk, rst, limit_detect_i, scl, host_low, sda_o, sda_oe, ok;
    logic                   irq_request, limit_active, limit_exp;
    pim_pkg::pim_flags_type flags;
    wire logic              sda_line;
    logic [2:0]             buck_thermal_irq, floor_sel, limit_sel, mask2_exp;
    logic [1:0]             blank_sel;
    logic [7:0]             group3_irq, mask3_exp, rd, v;
    logic [15:0]            lfsr_reg;
    int                     miscompares, checks, cycle_count;

    assign sda_line = !(host_low || (sda_oe && !sda_o));

    pim_regs #(.BLANK1_CYC(blank_cyc[1]), .BLANK2_CYC(blank_cyc[2]),
               .BLANK3_CYC(blank_cyc[3])) pim_regs_i (
        .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .flags(flags), .buck_thermal_irq(buck_thermal_irq),
        .group3_irq(group3_irq), .irq_request(irq_request),
        .limit_detect_i(limit_detect_i), .limit_active(limit_active),
        .system_floor_voltage_sel(floor_sel), .limiter_blanking_sel(blank_sel),
        .input_limit_sel(limit_sel));

    pim_host_model pim_host_model_i (.clk(clk), .sda_line(sda_line), .scl(scl),
                                     .sda_low(host_low));

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    always @(posedge clk)
    begin
        cycle_count++;
        if (cycle_count == 90000)
        begin
            $display("timeout at %0t", $time);
            miscompares++;
            wrap_up();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp)
        begin
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask : check

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic get_rand(output logic [7:0] r);
        lfsr_reg = lfsr_next(lfsr_reg);
        r = lfsr_reg[7:0];
    endtask : get_rand

    function automatic logic [11:0] exp_irq(input pim_pkg::pim_flags_type f,
                                            input logic [2:0] m2, input logic [7:0] m3);
        logic [2:0] bt;
        logic [7:0] g;
        bt = f.buck_thermal & m2;
        g = f.group3 & m3 & `PIM_MASK3_USED;
        return {(|bt) | (|g), bt, g};
    endfunction : exp_irq

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        pim_host_model_i.write_reg(`PIM_DEV_ADDR, addr, data, ok);
        check({11'h0, ok}, 12'h001);
    endtask : wr

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        pim_host_model_i.read_reg(addr, rd, ok);
        check({ok, 3'h0, rd}, {1'b1, 3'h0, exp});
    endtask : rd_chk

    task automatic flag_test(input int n);
        logic [7:0] r1, r2;
        repeat (n)
        begin
            get_rand(r1);
            get_rand(r2);
            flags = {r1[2:0], r2};
            tick(2);
            check({irq_request, buck_thermal_irq, group3_irq},
                  exp_irq(flags, mask2_exp, mask3_exp));
        end
    endtask : flag_test

    task automatic blank_test(input int code);
        int n;
        int cnt;
        n = blank_cyc[code];
        wr(`PIM_OFS_ILIM, {3'h0, code[1:0], 3'h0});
        if (n > 0)
        begin
            limit_detect_i = ~limit_exp;
            tick(n / 2);
            limit_detect_i = limit_exp;
            // short glitch still in flight, output must not have moved
            tick(2);
            check({11'h0, limit_active}, {11'h0, limit_exp});
        end
        limit_detect_i = ~limit_exp;
        limit_exp = ~limit_exp;
        cnt = 0;
        while (limit_active !== limit_exp && cnt < n + 10)
        begin
            tick(1);
            cnt++;
        end
        check({11'h0, cnt >= n + 2 && cnt <= n + 6}, 12'h001);
        $display("test blanking code %0d done after %0d cycles", code, cnt);
    endtask : blank_test

    initial
    begin
        rst = 1'b1;
        flags = '0;
        limit_detect_i = 1'b0;
        limit_exp = 1'b0;
        lfsr_reg = 16'h9240;
        mask2_exp = 3'h0;
        mask3_exp = 8'h00;
        miscompares = 0;
        checks = 0;
        cycle_count = 0;
        tick(6);
        rst = 1'b0;
        tick(2);
        rd_chk(`PIM_OFS_MASK2, 8'h00);
        rd_chk(`PIM_OFS_MASK3, 8'h00);
        rd_chk(`PIM_OFS_ILIM, 8'h00);
        flag_test(2);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            mask2_exp = (i < 3) ? 3'h1 << i : 3'h7;
            get_rand(v);
            wr(`PIM_OFS_MASK2, {v[7:3], mask2_exp});
            rd_chk(`PIM_OFS_MASK2, {5'h0, mask2_exp});
            flag_test(3);
        end
        $display("test buck masks done");
        for (int i = 0; i < 6; i++)
        begin
            if (i < 3)
                v = (i == 0) ? 8'h02 : (i == 1) ? 8'hff : 8'h10;
            else
                get_rand(v);
            mask3_exp = v;
            wr(`PIM_OFS_MASK3, v);
            rd_chk(`PIM_OFS_MASK3, v & `PIM_MASK3_USED);
            flag_test(3);
        end
        pim_host_model_i.write_reg(`PIM_DEV_ADDR ^ 7'h01, `PIM_OFS_MASK3, 8'h00, ok);
        check({11'h0, ok}, 12'h000);
        rd_chk(`PIM_OFS_MASK3, mask3_exp & `PIM_MASK3_USED);
        $display("test group3 masks done");
        for (int i = 0; i < 9; i++)
        begin
            if (i < 8)
                v = {i[2:0], i[1:0], ~i[2:0]};
            else
                get_rand(v);
            wr(`PIM_OFS_ILIM, v);
            rd_chk(`PIM_OFS_ILIM, v);
            check({4'h0, floor_sel, blank_sel, limit_sel}, {4'h0, v});
        end
        wr(8'h0e, 8'h5a);
        rd_chk(8'h0e, 8'h00);
        rd_chk(`PIM_OFS_ILIM, v);
        $display("test limit control done");
        for (int c = 0; c < 4; c++)
            blank_test(c);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
